// ### rtl/hwmon_host_regs_and_alarms.sv
`timescale 1ns/1ps
// Contract
// - Bit 1 of index 52h in banks 1 and 2 picks over-temp mode.
// - Comparator mode: alarm on over limit, drop below hysteresis.
// - Interrupt mode: over limit latches alarm until sensor register read.
// - After read-clear, falling below hysteresis latches alarm again.
// - After read-clear, no reassert while above hysteresis.
// - Index port bit 7 is busy; set by index write or serial activity.
// - Busy clears on data access, or when serial transaction ends.
// - Index port bits 6:0 are a pointer, reset zero.
// - Data port reads and writes the register at the pointer.
// - Access at 41h, 43h, 45h moves pointer to the next index.
// - Ranges 00h-1Fh and 60h-7Fh auto-increment, saturating at top.
// - Config bit 7 restores defaults except serial address; self-clears.
// - Config bit 6 drives the beep pin low.
// - Config bit 3 halts monitoring and interrupt, keeps status.
// - Config bit 1 enables the interrupt output.
// - Config bit 0 starts monitoring; zero is standby.
// - Clearing enables does not release an active interrupt pin.
// - Status 1 flags tach_two, tach_one, temp2, temp1, +5, +3.3, spare, core.
// - Status 2 flags temp3, intrusion, tach_three, -5, -12, +12; top zero.
// - Mask bits set keep matching status from the interrupt.
// - Intrusion clear bit 7 clears latched intrusion, then self-clears.
// - Reading a status register clears its pending events.
module hwmon_host_regs_and_alarms
   import hwmon_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Host port access, one-cycle strobes
   input wire hwmon_pkg::host_req_s host_req,
   output logic [7:0] host_rdata,
   // Serial bus activity, from pin logic
   input wire logic serial_busy,
   // Monitoring events, one-cycle pulses; intrusion is a level
   input wire logic [7:0] event_low,
   input wire logic [5:0] event_high,
   input wire logic intrusion_level,
   // Sensor 2 and 3 comparisons
   input wire hwmon_pkg::temp_cmp_s temp_two_cmp,
   input wire hwmon_pkg::temp_cmp_s temp_three_cmp,
   input wire logic temp_sensor_read,
   // Outputs, active low
   output logic over_temp_alarm_out_n,
   output logic system_mgmt_irq_out_n,
   output logic beep_gp_out_pin_n,
   // Monitoring run state
   output logic monitor_running
);
   import hwmon_pkg::*;

   // ****************
   // State
   // ****************
   typedef struct packed {
      logic [1:0] ser_sync;
      logic [1:0] intr_sync;
      logic busy_host;
      logic [6:0] pointer;
      logic [7:0] cfg;
      logic [7:0] flags_low;
      logic [7:0] flags_high;
      logic [7:0] mask_low;
      logic [7:0] mask_high;
      logic [6:0] two_wire_addr;
      logic [1:0] ovt_mode;
      logic irq;
      logic [7:0] rdata;
   } regs_state_s;

   regs_state_s q;
   regs_state_s next_q;
   logic [7:0] post_ram [0:31];
   logic [7:0] value_ram [0:31];
   logic data_access;
   logic [7:0] sel_data;
   logic run;
   logic ser_busy_s;
   logic [1:0] alarm;
   logic [7:0] pending_low;
   logic [5:0] pending_high;

   assign ser_busy_s = q.ser_sync[1];
   assign data_access = (host_req.rd || host_req.wr) && host_req.addr == port_data;
   assign run = q.cfg[cfg_start] && !q.cfg[cfg_smi_hold];

   // ****************
   // Read mux
   // ****************
   always_comb begin
      sel_data = 8'h00;
      if (q.pointer <= idx_post_top) begin
         sel_data = post_ram[q.pointer[4:0]];
      end else if (q.pointer >= idx_value_low) begin
         sel_data = value_ram[q.pointer[4:0]];
      end else begin
         unique case (q.pointer)
            idx_config: sel_data = q.cfg;
            idx_flags_low: sel_data = q.flags_low;
            idx_flags_high: sel_data = {2'b00, q.flags_high[5:0]};
            idx_mask_low: sel_data = q.mask_low;
            idx_mask_high: sel_data = q.mask_high & mask_high_used;
            idx_two_wire_addr: sel_data = {1'b0, q.two_wire_addr};
            idx_ovt_mode: sel_data = {6'h00, q.ovt_mode[0], 1'b0};
            default: sel_data = 8'h00;
         endcase
      end
   end

   // ****************
   // Main update
   // ****************
   always_comb begin
      next_q = q;
      pending_low = event_low;
      pending_high = event_high;
      next_q.ser_sync = {q.ser_sync[0], serial_busy};
      next_q.intr_sync = {q.intr_sync[0], intrusion_level};
      pending_high[flag_intrusion] = event_high[flag_intrusion] || q.intr_sync[1];
      // Index port
      if (host_req.wr && host_req.addr == port_index) begin
         next_q.pointer = host_req.wdata[6:0];
         next_q.busy_host = 1'b1;
      end
      if (host_req.rd && host_req.addr == port_index) begin
         next_q.rdata = {q.busy_host || ser_busy_s, q.pointer};
      end
      // Data port
      if (data_access) begin
         next_q.busy_host = 1'b0;
         if (host_req.rd) begin
            next_q.rdata = sel_data;
            if (q.pointer == idx_flags_low) begin
               next_q.flags_low = 8'h00;
            end
            if (q.pointer == idx_flags_high) begin
               next_q.flags_high = 8'h00;
            end
         end
         if (host_req.wr) begin
            unique case (q.pointer)
               idx_config: next_q.cfg = host_req.wdata;
               idx_mask_low: next_q.mask_low = host_req.wdata;
               idx_mask_high: next_q.mask_high = host_req.wdata & mask_high_used;
               idx_two_wire_addr: next_q.two_wire_addr = host_req.wdata[6:0];
               idx_ovt_mode: next_q.ovt_mode = {2{host_req.wdata[ovt_mode_bit]}};
               idx_intrusion_clear: begin
                  // Bit self-clears, so it always reads back zero
                  if (host_req.wdata[intrusion_clear_bit]) begin
                     next_q.flags_high[flag_intrusion] = 1'b0;
                  end
               end
               default: begin
               end
            endcase
         end
         // Pointer advance
         if (q.pointer == idx_flags_low || q.pointer == idx_mask_low
               || q.pointer == idx_unused) begin
            next_q.pointer = q.pointer + 7'h01;
         end else if ((q.pointer < idx_post_top)
               || (q.pointer >= idx_value_low && q.pointer < idx_value_top)) begin
            next_q.pointer = q.pointer + 7'h01;
         end
      end
      // Status flags: a new event wins over a read clear
      if (run) begin
         next_q.flags_low = next_q.flags_low | pending_low;
         next_q.flags_high = next_q.flags_high | {2'b00, pending_high};
      end
      // Interrupt: enable and hold gate new assertions only; release waits for no unmasked flags
      if (q.cfg[cfg_smi_enable] && !q.cfg[cfg_smi_hold]
            && (|(q.flags_low & ~q.mask_low)
            || |(q.flags_high[5:0] & ~q.mask_high[5:0]))) begin
         next_q.irq = 1'b1;
      end else if (!(|(q.flags_low & ~q.mask_low))
            && !(|(q.flags_high[5:0] & ~q.mask_high[5:0]))) begin
         next_q.irq = 1'b0;
      end
      // Soft reset keeps the serial address
      if (data_access && host_req.wr && q.pointer == idx_config
            && host_req.wdata[cfg_soft_reset]) begin
         next_q.cfg = config_reset;
         next_q.flags_low = 8'h00;
         next_q.flags_high = 8'h00;
         next_q.mask_low = mask_reset;
         next_q.mask_high = mask_reset;
         next_q.ovt_mode = 2'b00;
         next_q.irq = 1'b0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         q <= '{ser_sync: 2'b00, intr_sync: 2'b00, busy_host: 1'b0, pointer: 7'h00,
            cfg: config_reset, flags_low: 8'h00, flags_high: 8'h00,
            mask_low: mask_reset, mask_high: mask_reset,
            two_wire_addr: two_wire_addr_reset, ovt_mode: 2'b00, irq: 1'b0,
            rdata: 8'h00};
      end else begin
         q <= next_q;
      end
   end

   // ****************
   // Scratch memories
   // ****************
   always_ff @(posedge clk_sys) begin
      if (data_access && host_req.wr && q.pointer <= idx_post_top) begin
         post_ram[q.pointer[4:0]] <= host_req.wdata;
      end
      if (data_access && host_req.wr && q.pointer >= idx_value_low) begin
         value_ram[q.pointer[4:0]] <= host_req.wdata;
      end
   end

   // ****************
   // Over-temperature channels
   // ****************
   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : gen_ovt
         ovt_channel u_ovt (
            .clk_sys(clk_sys),
            .rst(rst),
            .run(run),
            .comparator_mode(!q.ovt_mode[0]),
            .sensor_read(temp_sensor_read),
            .cmp(g == 0 ? temp_two_cmp : temp_three_cmp),
            .alarm(alarm[g])
         );
      end
   endgenerate

   assign host_rdata = q.rdata;
   assign over_temp_alarm_out_n = !(|alarm);
   assign system_mgmt_irq_out_n = !q.irq;
   assign beep_gp_out_pin_n = !q.cfg[cfg_beep_low];
   assign monitor_running = run;
endmodule

// ### rtl/hwmon_pkg.sv
package hwmon_pkg;
   // ****************
   // Ports and indices
   // ****************
   localparam logic [2:0] port_index = 3'h5;
   localparam logic [2:0] port_data = 3'h6;
   localparam logic [6:0] idx_config = 7'h40;
   localparam logic [6:0] idx_flags_low = 7'h41;
   localparam logic [6:0] idx_flags_high = 7'h42;
   localparam logic [6:0] idx_mask_low = 7'h43;
   localparam logic [6:0] idx_mask_high = 7'h44;
   localparam logic [6:0] idx_unused = 7'h45;
   localparam logic [6:0] idx_intrusion_clear = 7'h46;
   localparam logic [6:0] idx_two_wire_addr = 7'h48;
   localparam logic [6:0] idx_ovt_mode = 7'h52;
   localparam logic [6:0] idx_post_top = 7'h1f;
   localparam logic [6:0] idx_value_low = 7'h60;
   localparam logic [6:0] idx_value_top = 7'h7f;
   // ****************
   // Field positions
   // ****************
   localparam int cfg_soft_reset = 7;
   localparam int cfg_beep_low = 6;
   localparam int cfg_smi_hold = 3;
   localparam int cfg_smi_enable = 1;
   localparam int cfg_start = 0;
   localparam int busy_bit = 7;
   localparam int intrusion_clear_bit = 7;
   localparam int ovt_mode_bit = 1;
   localparam int flag_intrusion = 4;
   // ****************
   // Reset values
   // ****************
   localparam logic [7:0] config_reset = 8'h01;
   localparam logic [7:0] mask_reset = 8'h00;
   localparam logic [6:0] two_wire_addr_reset = 7'h2d;
   localparam logic [7:0] mask_high_used = 8'h3f;

   typedef struct packed {
      logic rd;
      logic wr;
      logic [2:0] addr;
      logic [7:0] wdata;
   } host_req_s;

   typedef struct packed {
      logic over_limit;
      logic below_hyst;
   } temp_cmp_s;
endpackage

// ### rtl/ovt_channel.sv
`timescale 1ns/1ps
module ovt_channel
   import hwmon_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Control
   input wire logic run,
   input wire logic comparator_mode,
   input wire logic sensor_read,
   input wire hwmon_pkg::temp_cmp_s cmp,
   // Alarm
   output logic alarm
);
   import hwmon_pkg::*;

   typedef enum logic [1:0] {
      st_idle = 2'b00,
      st_hot = 2'b01,
      st_cleared_hot = 2'b10
   } ovt_e;

   typedef struct packed {
      ovt_e st;
      logic alarm;
   } ovt_state_s;

   ovt_state_s q;
   ovt_state_s next_q;

   always_comb begin
      next_q = q;
      if (comparator_mode) begin
         next_q.st = st_idle;
         if (run && cmp.over_limit) begin
            next_q.alarm = 1'b1;
         end else if (run && cmp.below_hyst) begin
            next_q.alarm = 1'b0;
         end
      end else begin
         if (sensor_read) begin
            next_q.alarm = 1'b0;
         end
         unique case (q.st)
            st_idle: begin
               if (run && cmp.over_limit) begin
                  next_q.alarm = 1'b1;
                  next_q.st = st_hot;
               end
            end
            st_hot: begin
               if (sensor_read) begin
                  next_q.st = st_cleared_hot;
               end
            end
            st_cleared_hot: begin
               // Staying above hysteresis never re-arms
               if (run && cmp.below_hyst) begin
                  next_q.alarm = 1'b1;
                  next_q.st = st_idle;
               end
            end
            default: begin
               next_q.st = st_idle;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         q <= '{st: st_idle, alarm: 1'b0};
      end else begin
         q <= next_q;
      end
   end

   assign alarm = q.alarm;
endmodule

// ### sim/hwmon_assertions.sv
`timescale 1ns/1ps
// ****************
// Port checker
// ****************
module hwmon_assertions (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Host and serial side
   input wire hwmon_pkg::host_req_s host_req,
   input wire logic [7:0] host_rdata,
   input wire logic serial_busy,
   // Outputs
   input wire logic system_mgmt_irq_out_n,
   input wire logic beep_gp_out_pin_n,
   input wire logic monitor_running
);
   import hwmon_pkg::*;
   logic wi, ri, da;
   logic [6:0] wp;
   logic [7:0] wd;
   assign wi = host_req.wr && host_req.addr == port_index;
   assign ri = host_req.rd && host_req.addr == port_index;
   assign da = (host_req.rd || host_req.wr) && host_req.addr == port_data;
   assign wp = host_req.wdata[6:0];
   assign wd = host_req.wdata;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   // Soft reset writes excluded, they rewrite config, flags, masks, mode and interrupt
   sequence s_cfg;
      wi && wp == idx_config ##1 host_req.wr && da && !wd[7];
   endsequence
   sequence s_step;
      wi && (wp < 7'h1f || (wp >= 7'h60 && wp < 7'h7f) || wp inside {7'h41, 7'h43, 7'h45})
         ##1 da ##1 ri;
   endsequence
   sequence s_top;
      wi && (wp == 7'h1f || wp == 7'h7f) ##1 da ##1 ri;
   endsequence
   a_rdata_holds: assert property (!host_req.rd |=> $stable(host_rdata))
      else $error("read data moved without a read");
   a_pointer_step: assert property (s_step |=> host_rdata[6:0] == $past(wp, 3) + 7'h1)
      else $error("pointer did not advance");
   a_pointer_top: assert property (s_top |=> host_rdata[6:0] == $past(wp, 3))
      else $error("pointer did not stop at range top");
   a_busy_on_write: assert property (wi ##1 ri |=> host_rdata == {1'b1, $past(wp, 2)})
      else $error("index write not seen as busy");
   a_busy_off_data: assert property ((!serial_busy) [*4] ##0 da ##1 ri |=> !host_rdata[7])
      else $error("busy kept after data access");
   a_serial_busy: assert property (serial_busy [*4] ##0 ri |=> host_rdata[7])
      else $error("serial activity not seen as busy");
   a_run_from_cfg: assert property (s_cfg |=> monitor_running == ($past(wd[0]) && !$past(wd[3])))
      else $error("run state does not follow config");
   a_beep_from_cfg: assert property (s_cfg ##1 (!host_req.wr) [*2] |=>
      beep_gp_out_pin_n == !$past(wd[6], 3)) else $error("beep pin does not follow config");
   a_irq_kept: assert property (s_cfg ##0 (!system_mgmt_irq_out_n && !wd[1])
      |=> !system_mgmt_irq_out_n) else $error("enable clear dropped interrupt");
endmodule

bind hwmon_host_regs_and_alarms hwmon_assertions hwmon_assertions_i (.clk_sys, .rst, .host_req,
   .host_rdata, .serial_busy, .system_mgmt_irq_out_n, .beep_gp_out_pin_n, .monitor_running);

// ### sim/hwmon_host_model.sv
`timescale 1ns/1ps
// ****************
// Host side model
// ****************
module hwmon_host_model (
   // Clock
   input wire logic clk_sys,
   // Requests
   output hwmon_pkg::host_req_s host_req,
   output logic serial_busy
);
   import hwmon_pkg::*;
   initial begin
      host_req = '0;
      serial_busy = 1'b0;
   end
   // Request holds until the next call; back-to-back calls give back-to-back strobes
   task automatic acc(input logic r, input logic w, input logic [2:0] a, input logic [7:0] d);
      @(negedge clk_sys);
      host_req = '{r, w, a, d};
   endtask
   // Serial activity level, set with no regard to host port traffic
   task automatic link(input logic b);
      @(negedge clk_sys);
      serial_busy = b;
   endtask
endmodule

// ### sim/hwmon_host_regs_and_alarms_tb.sv
`timescale 1ns/1ps
module hwmon_host_regs_and_alarms_tb;
   import hwmon_pkg::*;
   typedef struct packed {
      logic [6:0] ptr;
      logic [6:0] nxt;
   } step_s;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   host_req_s host_req;
   logic serial_busy;
   logic [7:0] host_rdata;
   logic [7:0] event_low = 8'h00;
   logic [5:0] event_high = 6'h00;
   logic intrusion_level = 1'b0;
   temp_cmp_s temp_two_cmp = 2'b00;
   temp_cmp_s temp_three_cmp = 2'b00;
   logic temp_sensor_read = 1'b0;
   logic over_temp_alarm_out_n, system_mgmt_irq_out_n, beep_gp_out_pin_n, monitor_running;
   logic [7:0] outs;
   int err_total = 0;
   int n_tests = 0;
   int cyc = 0;
   step_s rows [10] = '{'{7'h00, 7'h01}, '{7'h1e, 7'h1f}, '{7'h1f, 7'h1f}, '{7'h41, 7'h42},
      '{7'h43, 7'h44}, '{7'h45, 7'h46}, '{7'h60, 7'h61}, '{7'h7e, 7'h7f}, '{7'h7f, 7'h7f},
      '{7'h40, 7'h40}};
   // Alarm, interrupt, beep, run packed so one compare covers all
   assign outs = {4'h0, over_temp_alarm_out_n, system_mgmt_irq_out_n, beep_gp_out_pin_n,
      monitor_running};
   hwmon_host_model host (.clk_sys, .host_req, .serial_busy);
   hwmon_host_regs_and_alarms hwmon_host_regs_and_alarms_i (.clk_sys, .rst, .host_req,
      .host_rdata, .serial_busy, .event_low, .event_high, .intrusion_level, .temp_two_cmp,
      .temp_three_cmp, .temp_sensor_read, .over_temp_alarm_out_n, .system_mgmt_irq_out_n,
      .beep_gp_out_pin_n, .monitor_running);
   always #5 clk_sys = ~clk_sys;
   // Generous ceiling, the sequence needs well under a thousand cycles
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         err_total++;
         test_done;
      end
   end
   task automatic test_done;
      if (err_total == 0 && n_tests > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic w(input int n);
      repeat (n) @(negedge clk_sys);
   endtask
   task automatic put(input logic [6:0] i, input logic [7:0] d);
      host.acc(1'b0, 1'b1, port_index, {1'b0, i});
      host.acc(1'b0, 1'b1, port_data, d);
      host.acc(1'b0, 1'b0, 3'h0, 8'h00);
   endtask
   task automatic get(input logic [6:0] i, input logic [7:0] e);
      host.acc(1'b0, 1'b1, port_index, {1'b0, i});
      host.acc(1'b1, 1'b0, port_data, 8'h00);
      host.acc(1'b0, 1'b0, 3'h0, 8'h00);
      chk(host_rdata, e);
   endtask
   task automatic pulse(input logic [7:0] lo, input logic [5:0] hi);
      @(negedge clk_sys);
      event_low = lo;
      event_high = hi;
      @(negedge clk_sys);
      event_low = 8'h00;
      event_high = 6'h00;
      w(2);
   endtask
   task automatic sread;
      @(negedge clk_sys);
      temp_sensor_read = 1'b1;
      @(negedge clk_sys);
      temp_sensor_read = 1'b0;
      w(3);
   endtask
   initial begin
      w(20);
      rst = 1'b0;
      host.acc(1'b1, 1'b0, port_index, 8'h00);
      host.acc(1'b0, 1'b0, 3'h0, 8'h00);
      chk(host_rdata, 8'h00);
      chk(outs, 8'h0f);
      get(idx_config, config_reset);
      get(idx_mask_low, 8'h00);
      get(idx_two_wire_addr, 8'h2d);
      foreach (rows[k]) begin
         host.acc(1'b0, 1'b1, port_index, {1'b0, rows[k].ptr});
         host.acc(1'b0, 1'b1, port_data, 8'h00);
         host.acc(1'b1, 1'b0, port_index, 8'h00);
         host.acc(1'b0, 1'b0, 3'h0, 8'h00);
         chk(host_rdata, {1'b0, rows[k].nxt});
      end
      host.acc(1'b0, 1'b1, port_index, 8'h05);
      host.acc(1'b1, 1'b0, port_index, 8'h00);
      host.acc(1'b0, 1'b0, 3'h0, 8'h00);
      chk(host_rdata, 8'h85);
      host.link(1'b1);
      w(4);
      host.acc(1'b1, 1'b0, port_index, 8'h00);
      host.acc(1'b0, 1'b0, 3'h0, 8'h00);
      chk(host_rdata, 8'h85);
      host.link(1'b0);
      host.acc(1'b0, 1'b1, port_data, 8'h00);
      host.acc(1'b0, 1'b0, 3'h0, 8'h00);
      w(3);
      host.acc(1'b1, 1'b0, port_index, 8'h00);
      host.acc(1'b0, 1'b0, 3'h0, 8'h00);
      chk(host_rdata, 8'h06);
      put(idx_config, 8'h03);
      pulse(8'h20, 6'h00);
      chk(outs, 8'h0b);
      put(idx_config, 8'h01);
      w(2);
      chk(outs, 8'h0b);
      get(idx_flags_low, 8'h20);
      get(idx_flags_low, 8'h00);
      put(idx_mask_low, 8'h20);
      put(idx_config, 8'h03);
      pulse(8'h20, 6'h00);
      chk(outs, 8'h0f);
      get(idx_flags_low, 8'h20);
      put(idx_mask_high, 8'hff);
      get(idx_mask_high, 8'h3f);
      pulse(8'h00, 6'h3f);
      chk(outs, 8'h0f);
      get(idx_flags_high, 8'h3f);
      intrusion_level = 1'b1;
      w(4);
      intrusion_level = 1'b0;
      put(idx_intrusion_clear, 8'h80);
      get(idx_flags_high, 8'h00);
      get(idx_intrusion_clear, 8'h00);
      intrusion_level = 1'b1;
      w(4);
      intrusion_level = 1'b0;
      get(idx_flags_high, 8'h10);
      put(idx_config, 8'h00);
      chk(outs, 8'h0e);
      pulse(8'h01, 6'h00);
      get(idx_flags_low, 8'h00);
      put(idx_config, 8'h09);
      chk(outs, 8'h0e);
      put(idx_config, 8'h41);
      w(2);
      chk(outs, 8'h0d);
      put(idx_two_wire_addr, 8'h11);
      put(idx_config, 8'h80);
      w(2);
      get(idx_config, 8'h01);
      get(idx_mask_low, 8'h00);
      get(idx_two_wire_addr, 8'h11);
      put(idx_ovt_mode, 8'h02);
      temp_two_cmp = 2'b10;
      w(3);
      temp_two_cmp = 2'b00;
      w(3);
      chk(outs, 8'h07);
      sread;
      chk(outs, 8'h0f);
      temp_two_cmp = 2'b10;
      w(3);
      chk(outs, 8'h0f);
      temp_two_cmp = 2'b01;
      w(3);
      chk(outs, 8'h07);
      temp_two_cmp = 2'b00;
      sread;
      chk(outs, 8'h0f);
      put(idx_ovt_mode, 8'h00);
      temp_three_cmp = 2'b10;
      w(3);
      chk(outs, 8'h07);
      temp_three_cmp = 2'b00;
      w(3);
      chk(outs, 8'h07);
      temp_three_cmp = 2'b01;
      w(3);
      chk(outs, 8'h0f);
      test_done;
   end
endmodule
